// >>> shared/ctfr_defines.svh
// Purpose: Command codes, field positions, reset values and timing for the fault response block.
// Assumes: 20 MHz core clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef CTFR_DEFINES_SVH
`define CTFR_DEFINES_SVH

`define CTFR_CMD_OC_WARN      8'h4A
`define CTFR_CMD_UC_LIMIT     8'h4B
`define CTFR_CMD_UC_ACTION    8'h4C
`define CTFR_CMD_OT_LIMIT     8'h4F
`define CTFR_CMD_OT_ACTION    8'h50

`define CTFR_RST_OC_WARN      16'h0000
`define CTFR_RST_UC_LIMIT     16'h0000
`define CTFR_RST_OT_LIMIT     16'h7BFF
`define CTFR_RST_ACTION       8'h00

`define CTFR_RESP_MSB         7
`define CTFR_RESP_LSB         6
`define CTFR_RETRY_MSB        5
`define CTFR_RETRY_LSB        3
`define CTFR_DELAY_MSB        2
`define CTFR_DELAY_LSB        0

`define CTFR_RESP_IGNORE      2'h0
`define CTFR_RESP_CONTINUE    2'h1
`define CTFR_RESP_RETRY       2'h2
`define CTFR_RESP_HOLD        2'h3

`define CTFR_CLK_PERIOD_NS    50
`define CTFR_UC_CONT_UNIT_US  10000
`define CTFR_UC_RETRY_UNIT_US 8200
`define CTFR_OT_UNIT_US       1000
`define CTFR_US_TO_CYC(us)    ((us) * 1000 / `CTFR_CLK_PERIOD_NS)

`endif

// >>> shared/ctfr_pkg.sv
// Purpose: Types and the linear-format helper for the fault response block.
// Assumes: Linear values carry a 5-bit signed exponent over an 11-bit signed mantissa.
// Notes: Every design module keeps its whole state in one packed struct from here.
package ctfr_pkg;

    typedef enum logic [2:0] {ST_RUN, ST_DELAY, ST_RETRY_WAIT, ST_LATCHED, ST_HOLD} ctfr_fsm_t;

    typedef struct packed {
        ctfr_fsm_t   st;
        logic [7:0]  unitsLeft;
        logic [23:0] cyc;
        logic [2:0]  left;
        logic        retrying;
        logic        off;
        logic        evt;
    } ctfr_eng_t;

    typedef struct packed {
        logic cond;
        logic strobe;
    } ctfr_cmp_t;

    typedef struct packed {
        logic [15:0] ocWarn;
        logic [15:0] ucLimit;
        logic [7:0]  ucAction;
        logic [15:0] otLimit;
        logic [7:0]  otAction;
        logic [15:0] rdData;
        logic        rdValid;
        logic        reject;
        logic        ucStat;
        logic        otStat;
        logic        alertN;
        logic        outEn;
    } ctfr_top_t;

    // Scales a linear value by 2^16 so that every legal value becomes an exact signed integer.
    function automatic logic signed [47:0] ctfr_lin_to_fixed(input logic [15:0] v);
        logic signed [47:0] m;
        logic [5:0]         sh;
        m  = {{37{v[10]}}, v[10:0]};
        sh = 6'({v[15], v[15:11]} + 6'd16);
        return m <<< sh;
    endfunction

endpackage

// >>> src/ctfr_limit_cmp.sv
// Purpose: Compares one linear-format measurement against its limit on each monitor update.
// Assumes: Measurement and limit share the linear format.
// Notes: The result holds between updates; strobe marks a fresh result.
`timescale 1ns/1ps
`default_nettype none
module ctfr_limit_cmp
    import ctfr_pkg::*;
#(
    parameter bit ABOVE = 1'b1
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        update,
    input  wire logic [15:0] meas,
    input  wire logic [15:0] limit,
    output logic             cond,
    output logic             strobe
);

    ctfr_cmp_t q;
    ctfr_cmp_t d;

    always_comb
    begin
        d        = q;
        d.strobe = update;
        if (update)
        begin
            if (ABOVE)
                d.cond = ctfr_lin_to_fixed(meas) > ctfr_lin_to_fixed(limit);
            else
                d.cond = ctfr_lin_to_fixed(meas) < ctfr_lin_to_fixed(limit);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign cond   = q.cond;
    assign strobe = q.strobe;

    property p_cmpFresh;
        @(posedge core_clk) disable iff (!rst_n)
        update && (ABOVE ? (ctfr_lin_to_fixed(meas) > ctfr_lin_to_fixed(limit))
                         : (ctfr_lin_to_fixed(meas) < ctfr_lin_to_fixed(limit))) |=> cond && strobe;
    endproperty
    a_cmpFresh: assert property (p_cmpFresh) else $error("Limit breach not flagged after update.");

endmodule // ctfr_limit_cmp
`default_nettype wire

// >>> src/ctfr_fault_engine.sv
// Purpose: Carries out the programmed response to one fault: ignore, continue, retry or hold off.
// Assumes: sample marks a fresh cond; clearFaults is a one-cycle pulse.
// Notes: EXP_DELAY selects 2^n units instead of n units.
`timescale 1ns/1ps
`default_nettype none
`include "ctfr_defines.svh"
module ctfr_fault_engine
    import ctfr_pkg::*;
#(
    parameter int unsigned CONT_UNIT_CYC  = 1,
    parameter int unsigned RETRY_UNIT_CYC = 1,
    parameter bit          EXP_DELAY      = 1'b0
)
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sample,
    input  wire logic       cond,
    input  wire logic [7:0] action,
    input  wire logic       clearFaults,
    output logic            outputOff,
    output logic            faultEvent
);

    ctfr_eng_t  q;
    ctfr_eng_t  d;
    logic [1:0] resp;
    logic [2:0] retries;
    logic [7:0] units;
    logic       timerDone;

    assign resp    = action[`CTFR_RESP_MSB:`CTFR_RESP_LSB];
    assign retries = action[`CTFR_RETRY_MSB:`CTFR_RETRY_LSB];
    assign units   = EXP_DELAY ? 8'(9'h001 << action[`CTFR_DELAY_MSB:`CTFR_DELAY_LSB])
                               : {5'h00, action[`CTFR_DELAY_MSB:`CTFR_DELAY_LSB]};
    assign timerDone = (q.unitsLeft == 8'h00) || (q.cyc == 24'h000000 && q.unitsLeft == 8'h01);

    // Output goes off; a retry interval starts unless the attempt budget is spent.
    function automatic ctfr_eng_t shutDown(input ctfr_eng_t s, input logic [2:0] budget);
        ctfr_eng_t r;
        r     = s;
        r.off = 1'b1;
        if (budget == 3'h0)
            r.st = ST_LATCHED;
        else
        begin
            r.st        = ST_RETRY_WAIT;
            r.left      = budget - 3'h1;
            r.retrying  = 1'b1;
            r.unitsLeft = units;
            r.cyc       = 24'(RETRY_UNIT_CYC - 1);
        end
        return r;
    endfunction

    always_comb
    begin
        d     = q;
        d.evt = 1'b0;
        if ((q.st == ST_DELAY || q.st == ST_RETRY_WAIT) && !timerDone)
        begin
            if (q.cyc == 24'h000000)
            begin
                d.unitsLeft = q.unitsLeft - 8'h01;
                d.cyc       = (q.st == ST_DELAY) ? 24'(CONT_UNIT_CYC - 1) : 24'(RETRY_UNIT_CYC - 1);
            end
            else
                d.cyc = q.cyc - 24'h000001;
        end
        case (q.st)
            ST_RUN:
            begin
                d.off = 1'b0;
                if (sample && !cond)
                    d.retrying = 1'b0;
                if (sample && cond)
                begin
                    d.evt = 1'b1;
                    case (resp)
                        `CTFR_RESP_IGNORE: d.st = ST_RUN;
                        `CTFR_RESP_CONTINUE:
                        begin
                            d.st        = ST_DELAY;
                            d.unitsLeft = units;
                            d.cyc       = 24'(CONT_UNIT_CYC - 1);
                        end
                        `CTFR_RESP_RETRY: d = shutDown(d, q.retrying ? q.left : retries);
                        default:
                        begin
                            d.st  = ST_HOLD;
                            d.off = 1'b1;
                        end
                    endcase
                end
            end
            ST_DELAY:
            begin
                if (timerDone)
                begin
                    if (cond)
                        d = shutDown(d, q.retrying ? q.left : retries);
                    else
                        d.st = ST_RUN;
                end
            end
            ST_RETRY_WAIT:
            begin
                if (timerDone)
                begin
                    d.st  = ST_RUN;
                    d.off = 1'b0;
                end
            end
            ST_LATCHED:
            begin
                if (clearFaults)
                begin
                    d.st       = ST_RUN;
                    d.off      = 1'b0;
                    d.retrying = 1'b0;
                end
            end
            default:
            begin
                if (sample && !cond)
                begin
                    d.st  = ST_RUN;
                    d.off = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '{st: ST_RUN, default: '0};
        else
            q <= d;
    end

    assign outputOff  = q.off;
    assign faultEvent = q.evt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_ignoreRuns;
        q.st == ST_RUN && resp == `CTFR_RESP_IGNORE && sample && cond |=> !outputOff && q.st == ST_RUN;
    endproperty
    a_ignoreRuns: assert property (p_ignoreRuns) else $error("Ignored fault disturbed the output.");

    property p_contRuns;
        q.st == ST_RUN && resp == `CTFR_RESP_CONTINUE && sample && cond |=> !outputOff ##0 q.st == ST_DELAY;
    endproperty
    a_contRuns: assert property (p_contRuns) else $error("Continue mode did not keep running.");

    property p_disableNow;
        q.st == ST_RUN && resp == `CTFR_RESP_RETRY && sample && cond |=> outputOff;
    endproperty
    a_disableNow: assert property (p_disableNow) else $error("Disable mode left the output on.");

    property p_holdResume;
        q.st == ST_HOLD && sample && !cond |=> !outputOff ##1 q.st == ST_RUN || outputOff;
    endproperty
    a_holdResume: assert property (p_holdResume) else $error("Hold mode did not resume when clear.");

    property p_eventPulse;
        q.st == ST_RUN && sample && cond ##1 !sample |-> faultEvent ##1 !faultEvent;
    endproperty
    a_eventPulse: assert property (p_eventPulse) else $error("Fault event not a single pulse.");

    property p_noRetry;
        q.st == ST_RUN && resp == `CTFR_RESP_RETRY && sample && cond && !q.retrying && retries == 3'h0
        |=> q.st == ST_LATCHED;
    endproperty
    a_noRetry: assert property (p_noRetry) else $error("Zero retry budget did not latch off.");

    property p_latchStays;
        q.st == ST_LATCHED && !clearFaults |=> outputOff && q.st == ST_LATCHED;
    endproperty
    a_latchStays: assert property (p_latchStays) else $error("Latched output came back uncleared.");

    property p_retryWaitOff;
        q.st == ST_RETRY_WAIT && !timerDone |=> outputOff;
    endproperty
    a_retryWaitOff: assert property (p_retryWaitOff) else $error("Output on during retry interval.");

    c_retryCycle: cover property (q.st == ST_RETRY_WAIT ##1 q.st == ST_RUN);
    c_holdResume: cover property (q.st == ST_HOLD ##1 q.st == ST_RUN);

endmodule // ctfr_fault_engine
`default_nettype wire

// >>> src/ctfr_top.sv
// Purpose: Current and temperature limit registers with programmable undercurrent and
//          overtemperature fault responses.
// Assumes: Commands arrive already decoded from the management bus as code plus data strobes;
//          measurements arrive in linear format with a monitor update pulse.
// Notes: Status bits are sticky until clearFaults; a fault in the same cycle wins.
`timescale 1ns/1ps
`default_nettype none
`include "ctfr_defines.svh"
module ctfr_top
    import ctfr_pkg::*;
#(
    parameter int unsigned UC_CONT_UNIT_CYC  = `CTFR_US_TO_CYC(`CTFR_UC_CONT_UNIT_US),
    parameter int unsigned UC_RETRY_UNIT_CYC = `CTFR_US_TO_CYC(`CTFR_UC_RETRY_UNIT_US),
    parameter int unsigned OT_UNIT_CYC       = `CTFR_US_TO_CYC(`CTFR_OT_UNIT_US)
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cmdWrite,
    input  wire logic        cmdRead,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [15:0] cmdData,
    output logic      [15:0] rdData,
    output logic             rdValid,
    output logic             cmdReject,
    input  wire logic [15:0] measCurrent,
    input  wire logic [15:0] measTemp,
    input  wire logic        monitorUpdate,
    input  wire logic        clearFaults,
    output logic             outputEnable,
    output logic             hostAttentionLine_n,
    output logic             ucFaultStatus,
    output logic             otFaultStatus
);

    localparam ctfr_top_t TOP_RST = '{
        ocWarn:   `CTFR_RST_OC_WARN,
        ucLimit:  `CTFR_RST_UC_LIMIT,
        ucAction: `CTFR_RST_ACTION,
        otLimit:  `CTFR_RST_OT_LIMIT,
        otAction: `CTFR_RST_ACTION,
        rdData:   16'h0000,
        rdValid:  1'b0,
        reject:   1'b0,
        ucStat:   1'b0,
        otStat:   1'b0,
        alertN:   1'b1,
        outEn:    1'b1
    };

    ctfr_top_t q;
    ctfr_top_t d;
    logic      ucCond;
    logic      ucSample;
    logic      otCond;
    logic      otSample;
    logic      ucOff;
    logic      ucEvt;
    logic      otOff;
    logic      otEvt;

    // Undercurrent trips when the current falls below its limit.
    ctfr_limit_cmp #(
        .ABOVE (1'b0)
    ) u_ucCmp (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .update   (monitorUpdate),
        .meas     (measCurrent),
        .limit    (q.ucLimit),
        .cond     (ucCond),
        .strobe   (ucSample)
    );

    // Overtemperature trips when the temperature rises above its limit.
    ctfr_limit_cmp #(
        .ABOVE (1'b1)
    ) u_otCmp (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .update   (monitorUpdate),
        .meas     (measTemp),
        .limit    (q.otLimit),
        .cond     (otCond),
        .strobe   (otSample)
    );

    ctfr_fault_engine #(
        .CONT_UNIT_CYC  (UC_CONT_UNIT_CYC),
        .RETRY_UNIT_CYC (UC_RETRY_UNIT_CYC),
        .EXP_DELAY      (1'b0)
    ) u_ucEngine (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .sample      (ucSample),
        .cond        (ucCond),
        .action      (q.ucAction),
        .clearFaults (clearFaults),
        .outputOff   (ucOff),
        .faultEvent  (ucEvt)
    );

    ctfr_fault_engine #(
        .CONT_UNIT_CYC  (OT_UNIT_CYC),
        .RETRY_UNIT_CYC (OT_UNIT_CYC),
        .EXP_DELAY      (1'b1)
    ) u_otEngine (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .sample      (otSample),
        .cond        (otCond),
        .action      (q.otAction),
        .clearFaults (clearFaults),
        .outputOff   (otOff),
        .faultEvent  (otEvt)
    );

    always_comb
    begin
        d         = q;
        d.rdValid = 1'b0;
        d.reject  = 1'b0;

        // Writes to codes outside this block are refused with a one-cycle reject pulse.
        if (cmdWrite)
        begin
            if (cmdCode == `CTFR_CMD_OC_WARN)
                d.ocWarn = cmdData;
            else if (cmdCode == `CTFR_CMD_UC_LIMIT)
                d.ucLimit = cmdData;
            else if (cmdCode == `CTFR_CMD_UC_ACTION)
                d.ucAction = cmdData[7:0];
            else if (cmdCode == `CTFR_CMD_OT_LIMIT)
                d.otLimit = cmdData;
            else if (cmdCode == `CTFR_CMD_OT_ACTION)
                d.otAction = cmdData[7:0];
            else
                d.reject = 1'b1;
        end

        if (cmdRead)
        begin
            d.rdValid = 1'b1;
            if (cmdCode == `CTFR_CMD_OC_WARN)
                d.rdData = q.ocWarn;
            else if (cmdCode == `CTFR_CMD_UC_LIMIT)
                d.rdData = q.ucLimit;
            else if (cmdCode == `CTFR_CMD_UC_ACTION)
                d.rdData = {8'h00, q.ucAction};
            else if (cmdCode == `CTFR_CMD_OT_LIMIT)
                d.rdData = q.otLimit;
            else if (cmdCode == `CTFR_CMD_OT_ACTION)
                d.rdData = {8'h00, q.otAction};
            else
            begin
                d.rdData = 16'h0000;
                d.reject = 1'b1;
            end
        end

        // A fault arriving with the clear keeps its status bit.
        if (clearFaults)
        begin
            d.ucStat = 1'b0;
            d.otStat = 1'b0;
        end
        if (ucEvt)
            d.ucStat = 1'b1;
        if (otEvt)
            d.otStat = 1'b1;

        d.alertN = !(d.ucStat || d.otStat);
        d.outEn  = !(ucOff || otOff);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= TOP_RST;
        else
            q <= d;
    end

    assign rdData              = q.rdData;
    assign rdValid             = q.rdValid;
    assign cmdReject           = q.reject;
    assign outputEnable        = q.outEn;
    assign hostAttentionLine_n = q.alertN;
    assign ucFaultStatus       = q.ucStat;
    assign otFaultStatus       = q.otStat;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_ocWarnStore;
        cmdWrite && cmdCode == `CTFR_CMD_OC_WARN ##1 !cmdWrite
        ##1 cmdRead && !cmdWrite && cmdCode == `CTFR_CMD_OC_WARN
        |=> rdValid && rdData == $past(cmdData, 3);
    endproperty
    a_ocWarnStore: assert property (p_ocWarnStore) else $error("Warning threshold read back wrong.");

    property p_ucLimitStore;
        cmdWrite && cmdCode == `CTFR_CMD_UC_LIMIT |=> q.ucLimit == $past(cmdData);
    endproperty
    a_ucLimitStore: assert property (p_ucLimitStore) else $error("Undercurrent limit not stored.");

    property p_otLimitStore;
        cmdWrite && cmdCode == `CTFR_CMD_OT_LIMIT ##1 !cmdWrite
        ##1 cmdRead && !cmdWrite && cmdCode == `CTFR_CMD_OT_LIMIT
        |=> rdData == $past(cmdData, 3);
    endproperty
    a_otLimitStore: assert property (p_otLimitStore) else $error("Overtemperature limit read back wrong.");

    property p_alertOnFault;
        ucEvt || otEvt |=> !hostAttentionLine_n;
    endproperty
    a_alertOnFault: assert property (p_alertOnFault) else $error("Alert not pulled low on fault.");

    property p_ucStatusSet;
        ucEvt |=> ucFaultStatus and (!clearFaults |=> ucFaultStatus);
    endproperty
    a_ucStatusSet: assert property (p_ucStatusSet) else $error("Undercurrent status bit not set.");

    property p_offFollows;
        ucOff || otOff |=> !outputEnable;
    endproperty
    a_offFollows: assert property (p_offFollows) else $error("Output enable ignored a disable.");

    property p_ucDetect;
        monitorUpdate && ctfr_lin_to_fixed(measCurrent) < ctfr_lin_to_fixed(q.ucLimit)
        |=> ucCond && ucSample;
    endproperty
    a_ucDetect: assert property (p_ucDetect) else $error("Undercurrent compare failed.");

    property p_ocWarnHold;
        !(cmdWrite && cmdCode == `CTFR_CMD_OC_WARN) |=> $stable(q.ocWarn);
    endproperty
    a_ocWarnHold: assert property (p_ocWarnHold) else $error("Warning threshold changed.");

    property p_ucLimitHold;
        !(cmdWrite && cmdCode == `CTFR_CMD_UC_LIMIT) |=> $stable(q.ucLimit);
    endproperty
    a_ucLimitHold: assert property (p_ucLimitHold) else $error("Undercurrent limit changed.");

    property p_otLimitHold;
        !(cmdWrite && cmdCode == `CTFR_CMD_OT_LIMIT) |=> $stable(q.otLimit);
    endproperty
    a_otLimitHold: assert property (p_otLimitHold) else $error("Temperature limit changed.");

    property p_ucActionStore;
        cmdWrite && cmdCode == `CTFR_CMD_UC_ACTION |=> q.ucAction == 8'($past(cmdData));
    endproperty
    a_ucActionStore: assert property (p_ucActionStore) else $error("Undercurrent action lost.");

    property p_otActionStore;
        cmdWrite && cmdCode == `CTFR_CMD_OT_ACTION |=> q.otAction == 8'($past(cmdData));
    endproperty
    a_otActionStore: assert property (p_otActionStore) else $error("Temperature action lost.");

    property p_otStatusSet;
        otEvt |=> otFaultStatus;
    endproperty
    a_otStatusSet: assert property (p_otStatusSet) else $error("Temperature status not set.");

    property p_ucOwnBit;
        ucEvt && !otEvt && !otFaultStatus |=> ucFaultStatus && !otFaultStatus;
    endproperty
    a_ucOwnBit: assert property (p_ucOwnBit) else $error("Undercurrent set wrong bit.");

    property p_alertStays;
        (ucFaultStatus || otFaultStatus) && !clearFaults |=> !hostAttentionLine_n;
    endproperty
    a_alertStays: assert property (p_alertStays) else $error("Alert released early.");

    property p_clearDrops;
        clearFaults && !ucEvt && !otEvt |=> !ucFaultStatus && !otFaultStatus && hostAttentionLine_n;
    endproperty
    a_clearDrops: assert property (p_clearDrops) else $error("Clear left a fault set.");

    property p_ignoreStaysOn;
        ucEvt && q.ucAction[7:6] == 2'h0 && $stable(q.ucAction) && !otOff |=> outputEnable;
    endproperty
    a_ignoreStaysOn: assert property (p_ignoreStaysOn) else $error("Ignored fault cut output.");

    c_ucFault: cover property (ucEvt ##1 !hostAttentionLine_n);
    c_otFault: cover property (otEvt ##1 otFaultStatus);
    c_clearAll: cover property (ucFaultStatus ##1 clearFaults ##1 hostAttentionLine_n);

endmodule // ctfr_top
`default_nettype wire

// >>> verification/ctfr_host_model.sv
// Purpose: Host side of the command port, issuing one read or write at a time.
// Assumes: Strobes change at the falling edge and stand for one rising edge.
// Notes: The answer is taken in the cycle after the strobe edge; released lines show inverted values.
`timescale 1ns/1ps
`default_nettype none
module ctfr_host_model
(
    input  wire logic        core_clk,
    output logic             cmdWrite,
    output logic             cmdRead,
    output logic      [7:0]  cmdCode,
    output logic      [15:0] cmdData,
    input  wire logic [15:0] rdData,
    input  wire logic        rdValid,
    input  wire logic        cmdReject
);
    initial
    begin
        cmdWrite = 1'b0;
        cmdRead  = 1'b0;
        cmdCode  = 8'h00;
        cmdData  = 16'h0000;
    end

    task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] rd, output logic ok, output logic rej);
        @(negedge core_clk);
        cmdWrite = wr;
        cmdRead  = !wr;
        cmdCode  = c;
        cmdData  = d;
        @(negedge core_clk);
        rd       = rdData;
        ok       = rdValid;
        rej      = cmdReject;
        cmdWrite = 1'b0;
        cmdRead  = 1'b0;
        cmdCode  = ~c;
        cmdData  = ~d;
    endtask
endmodule // ctfr_host_model
`default_nettype wire

// >>> verification/current_temp_fault_response_test.sv
// Purpose: Self-checking bench for the limit registers and fault responses.
// Assumes: Shortened unit counts of 4, 3 and 2 cycles.
// Notes: A register model and expected output levels are kept in the bench.
`timescale 1ns/1ps
`default_nettype none
`include "ctfr_defines.svh"
module current_temp_fault_response_test;
    import ctfr_pkg::*;
    localparam int UC_C = 4;
    localparam int OT_U = 2;
    localparam logic [15:0] BAD = 16'h000A, GOOD = 16'h001E, HOT = 16'h0064, COOL = 16'h0010;
    logic        core_clk, rst_n, cmdWrite, cmdRead, rdValid, cmdReject, monitorUpdate, clearFaults;
    logic        outputEnable, hostAttentionLine_n, ucFaultStatus, otFaultStatus;
    logic [7:0]  cmdCode;
    logic [15:0] cmdData, rdData, measCurrent, measTemp;
    logic [15:0] regM [logic [7:0]];
    logic [31:0] lfsrQ;
    int          n_fail, num_checks;
    int          dly;

    ctfr_top #(.UC_CONT_UNIT_CYC(4), .UC_RETRY_UNIT_CYC(3), .OT_UNIT_CYC(2)) i_ctfr_top
    (
        .core_clk(core_clk), .rst_n(rst_n), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
        .cmdCode(cmdCode), .cmdData(cmdData), .rdData(rdData), .rdValid(rdValid),
        .cmdReject(cmdReject), .measCurrent(measCurrent), .measTemp(measTemp),
        .monitorUpdate(monitorUpdate), .clearFaults(clearFaults), .outputEnable(outputEnable),
        .hostAttentionLine_n(hostAttentionLine_n), .ucFaultStatus(ucFaultStatus),
        .otFaultStatus(otFaultStatus)
    );

    ctfr_host_model i_ctfr_host_model
    (
        .core_clk(core_clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
        .cmdData(cmdData), .rdData(rdData), .rdValid(rdValid), .cmdReject(cmdReject)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic        v;
        logic        j;
        i_ctfr_host_model.xfer(1'b1, c, d, r, v, j);
        chk(16'(j), 16'(!regM.exists(c)));
        if (regM.exists(c))
            regM[c] = (c == 8'h4C || c == 8'h50) ? {8'h00, d[7:0]} : d;
    endtask

    task automatic rdchk(input logic [7:0] c);
        logic [15:0] r;
        logic        v;
        logic        j;
        i_ctfr_host_model.xfer(1'b0, c, 16'h0000, r, v, j);
        chk(r, regM.exists(c) ? regM[c] : 16'h0000);
        chk(16'(j), 16'(!regM.exists(c)));
        if (regM.exists(c))
            chk(16'(v), 16'h0001);
    endtask

    task automatic upd(input logic [15:0] cur, input logic [15:0] tmp);
        @(negedge core_clk);
        measCurrent   = cur;
        measTemp      = tmp;
        monitorUpdate = 1'b1;
        @(negedge core_clk);
        monitorUpdate = 1'b0;
    endtask

    task automatic clr();
        @(negedge core_clk);
        clearFaults = 1'b1;
        @(negedge core_clk);
        clearFaults = 1'b0;
    endtask

    task automatic chkOut(input logic en, input logic uc, input logic ot);
        chk(16'({outputEnable, hostAttentionLine_n, ucFaultStatus, otFaultStatus}),
            16'({en, !(uc | ot), uc, ot}));
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        #(50 * 5000);
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        rst_n = 1'b0;
        measCurrent = GOOD;
        measTemp = COOL;
        monitorUpdate = 1'b0;
        clearFaults = 1'b0;
        n_fail = 0;
        num_checks = 0;
        lfsrQ = 32'hD60168B6;
        regM[8'h4A] = `CTFR_RST_OC_WARN;
        regM[8'h4B] = `CTFR_RST_UC_LIMIT;
        regM[8'h4C] = {8'h00, `CTFR_RST_ACTION};
        regM[8'h4F] = `CTFR_RST_OT_LIMIT;
        regM[8'h50] = {8'h00, `CTFR_RST_ACTION};
        cycles(2);
        rst_n = 1'b1;
        foreach (regM[c])
            rdchk(c);
        foreach (regM[c])
        begin
            lfsrQ = lfsr_next(lfsrQ);
            wr(c, lfsrQ[15:0]);
            rdchk(c);
        end
        rdchk(8'h4D);
        wr(8'h4E, 16'h1234);
        wr(8'h4B, 16'h0014);
        wr(8'h4F, 16'h0050);
        wr(8'h4C, 16'h0000);
        upd(BAD, COOL);
        cycles(2);
        chkOut(1, 1, 0);
        upd(GOOD, COOL);
        clr();
        cycles(3);
        chkOut(1, 0, 0);
        wr(8'h4C, 16'h008A);
        upd(BAD, COOL);
        cycles(2);
        chkOut(0, 1, 0);
        cycles(5);
        chkOut(0, 1, 0);
        cycles(1);
        chkOut(1, 1, 0);
        upd(BAD, COOL);
        cycles(2);
        chkOut(0, 1, 0);
        upd(GOOD, COOL);
        cycles(20);
        chkOut(0, 1, 0);
        clr();
        cycles(3);
        chkOut(1, 0, 0);
        wr(8'h4C, 16'h0080);
        upd(BAD, COOL);
        cycles(30);
        chkOut(0, 1, 0);
        upd(GOOD, COOL);
        clr();
        cycles(3);
        chkOut(1, 0, 0);
        wr(8'h4C, 16'h00C0);
        upd(BAD, COOL);
        cycles(2);
        chkOut(0, 1, 0);
        upd(GOOD, COOL);
        cycles(2);
        chkOut(1, 1, 0);
        clr();
        for (int k = 0; k < 2; k++)
        begin
            wr(k ? 8'h50 : 8'h4C, 16'h0043);
            upd(k ? GOOD : BAD, k ? HOT : COOL);
            dly = k ? 8 * OT_U : 3 * UC_C;
            cycles(dly + 1);
            chkOut(1, !k, k);
            cycles(1);
            chkOut(0, !k, k);
            upd(GOOD, COOL);
            clr();
            cycles(3);
            chkOut(1, 0, 0);
        end
        tally_and_finish();
    end
endmodule // current_temp_fault_response_test
`default_nettype wire
